/* File: ctse_core.sv */
// transfer, exchange, table lookup and skip execution logic
// Functional notes
// - taken skip cancels the next instruction's effects
// - counter steps by one past cancelled slot
// - cancelled slot takes one cycle whatever its normal count
// - cancelled lookup or return takes one cycle
// - data pointer is z, x, y concatenated
// - counter split into page and in-page parts
// - eight fourteen-bit return stack entries
// - three-bit stack index selects entry
// - e loads from b,acc and back
// - d copies acc low bits, acc3 cleared
// - lookup pushes index then saves counter
// - lookup page from operand, low from d,acc
// - lookup rom word to b,acc then restore
// - swap acc with ram, xor x, y+1
`timescale 1ns/1ps
`default_nettype none
module ctse_core
  import ctse_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // decoded instruction
  input wire logic op_valid_i,
  input wire logic [3:0] op_code_i,
  input wire logic [3:0] op_arg_i,
  input wire logic [6:0] op_page_i,
  input wire logic skip_cond_i,
  // program rom
  output logic [PC_W-1:0] rom_addr_o,
  input wire logic [ROM_W-1:0] rom_data_i,
  // data ram
  output logic [DP_W-1:0] ram_addr_o,
  output logic ram_we_o,
  output logic [3:0] ram_wdata_o,
  input wire logic [3:0] ram_rdata_i,
  // register view
  output logic [3:0] acc_o,
  output logic [3:0] b_o,
  output logic [7:0] e_o,
  output logic [2:0] d_o,
  output logic [3:0] x_o,
  output logic [3:0] y_o,
  output logic [1:0] z_o,
  output logic [PC_W-1:0] pc_o,
  output logic [SP_W-1:0] sp_o,
  output logic busy_o,
  output logic skip_pend_o
);
  // stack carrier
  ctse_stack_if sk ();
  ctse_stack #(.DEPTH(DEPTH)) u_stack (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clk_en_i(clk_en_i),
    .sk(sk)
  );
  // architectural registers
  logic [3:0] acc_reg, b_reg, x_reg, y_reg;
  logic [7:0] e_reg;
  logic [2:0] d_reg;
  logic [1:0] z_reg;
  logic [PAGE_W-1:0] pch_reg, pcl_reg; // page and in-page parts
  logic [SP_W-1:0] sp_reg;
  logic skip_reg; // next slot is cancelled
  logic busy_reg;
  logic ram_we_reg;
  logic [3:0] ram_wdata_reg;
  logic [PC_W-1:0] rom_addr_reg;
  // ram pointer view, trails the data pointer by one cycle after an exchange
  logic [DP_W-1:0] ram_addr_reg;
  logic [1:0] burn_reg; // extra cycles left
  ctse_state_t state_reg;

  // counter step used by every finished slot except a lookup or a return, which end by loading the counter from the stack
  function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc);
    pc_step = pc + 14'h0001;
  endfunction

  // decode views
  wire logic [PC_W-1:0] pc_cur = {pch_reg, pcl_reg};
  wire logic [DP_W-1:0] dp_cur = {z_reg, x_reg, y_reg};
  wire logic [PC_W-1:0] pc_inc = pc_step(pc_cur);
  // an exchange writes back one cycle late, at the pointer it read from;
  // a second exchange in that cycle would read through the stale pointer,
  // so it waits one cycle while the write-back pulse stands
  wire logic swap_hold = ram_we_reg && !skip_reg && (op_code_i == OP_SWAP_MEM_STEP_UP);
  wire logic issue = op_valid_i && (state_reg == ST_EXEC) && !swap_hold;
  wire logic cancel = issue && skip_reg;
  wire logic do_op = issue && !skip_reg;
  wire logic is_multi = (op_code_i == OP_TABLE_LOOKUP_CALL) || (op_code_i == OP_RETURN_OP);
  wire logic [SP_W-1:0] sp_up = sp_reg + 3'h1;
  wire logic [PAGE_W-1:0] tbl_low = {d_reg, acc_reg};
  // ram exchange strobe
  wire logic swap_go = do_op && (op_code_i == OP_SWAP_MEM_STEP_UP);
  // push on lookup
  wire logic push_go = do_op && (op_code_i == OP_TABLE_LOOKUP_CALL);

  assign sk.wr_en = push_go;
  assign sk.wr_idx = sp_up;
  assign sk.wr_data = pc_inc;
  assign sk.rd_idx = sp_reg;

  // outputs straight from flops
  assign acc_o = acc_reg;
  assign b_o = b_reg;
  assign e_o = e_reg;
  assign d_o = d_reg;
  assign x_o = x_reg;
  assign y_o = y_reg;
  assign z_o = z_reg;
  assign pc_o = {pch_reg, pcl_reg};
  assign sp_o = sp_reg;
  assign busy_o = busy_reg;
  assign skip_pend_o = skip_reg;
  assign rom_addr_o = rom_addr_reg;
  assign ram_addr_o = ram_addr_reg;
  assign ram_we_o = ram_we_reg;
  assign ram_wdata_o = ram_wdata_reg;

  // sequencer and register updates
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_reg <= NIB_RST;
      b_reg <= NIB_RST;
      x_reg <= NIB_RST;
      y_reg <= NIB_RST;
      e_reg <= 8'h00;
      d_reg <= 3'h0;
      z_reg <= 2'h0;
      pch_reg <= PC_RST[13:7];
      pcl_reg <= PC_RST[6:0];
      sp_reg <= SP_RST;
      skip_reg <= 1'b0;
      busy_reg <= 1'b0;
      ram_we_reg <= 1'b0;
      ram_wdata_reg <= NIB_RST;
      rom_addr_reg <= PC_RST;
      ram_addr_reg <= 10'h000;
      burn_reg <= 2'h0;
      state_reg <= ST_EXEC;
    end else if (clk_en_i) begin
      ram_we_reg <= 1'b0;
      // pointer view follows the data pointer one cycle behind, so the
      // write-back pulse of an exchange still addresses the nibble it read
      ram_addr_reg <= dp_cur;
      case (state_reg)
        ST_EXEC: begin
          if (cancel) begin
            // cancelled slot: no effect, counter steps once and the
            // sequencer stays in execute, so lookup and return shrink to one cycle
            skip_reg <= 1'b0;
            {pch_reg, pcl_reg} <= pc_inc;
            burn_reg <= 2'h0;
          end else if (do_op) begin
            {pch_reg, pcl_reg} <= pc_inc;
            case (op_code_i)
              OP_COPY_B_TO_ACC: acc_reg <= b_reg;
              OP_COPY_ACC_TO_B: b_reg <= acc_reg;
              OP_COPY_Y_TO_ACC: acc_reg <= y_reg;
              OP_COPY_ACC_TO_Y: y_reg <= acc_reg;
              OP_LOAD_E_FROM_B_ACC: e_reg <= {b_reg, acc_reg};
              OP_LOAD_B_ACC_FROM_E: begin
                b_reg <= e_reg[7:4];
                acc_reg <= e_reg[3:0];
              end
              OP_LOAD_D_FROM_ACC: d_reg <= acc_reg[2:0];
              OP_LOAD_ACC_FROM_D: acc_reg <= {1'b0, d_reg};
              OP_SWAP_MEM_STEP_UP: begin
                acc_reg <= ram_rdata_i;
                ram_wdata_reg <= acc_reg;
                ram_we_reg <= 1'b1;
                x_reg <= x_reg ^ op_arg_i;
                y_reg <= y_reg + 4'h1;
              end
              OP_TABLE_LOOKUP_CALL: begin
                sp_reg <= sp_up;
                rom_addr_reg <= {op_page_i, tbl_low};
                pch_reg <= op_page_i;
                pcl_reg <= tbl_low;
                busy_reg <= 1'b1;
                burn_reg <= CYC_LOOKUP - 2'h1;
                state_reg <= ST_FETCH_TBL;
              end
              OP_RETURN_OP: begin
                // return: pop, two cycles in total
                sp_reg <= sp_reg - 3'h1;
                {pch_reg, pcl_reg} <= sk.rd_data;
                busy_reg <= 1'b1;
                burn_reg <= CYC_RETURN - 2'h1;
                state_reg <= ST_BURN;
              end
              OP_SKIP_IF: skip_reg <= skip_cond_i;
              default: begin
              end
            endcase
          end
        end
        ST_FETCH_TBL: begin
          // rom word becomes valid this cycle
          burn_reg <= burn_reg - 2'h1;
          state_reg <= ST_LOAD_TBL;
        end
        ST_LOAD_TBL: begin
          b_reg <= rom_data_i[7:4];
          acc_reg <= rom_data_i[3:0];
          {pch_reg, pcl_reg} <= sk.rd_data;
          sp_reg <= sp_reg - 3'h1;
          busy_reg <= 1'b0;
          burn_reg <= 2'h0;
          state_reg <= ST_EXEC;
        end
        ST_BURN: begin
          // idle until the slot's count runs out
          if (burn_reg <= CYC_ONE) begin
            busy_reg <= 1'b0;
            burn_reg <= 2'h0;
            state_reg <= ST_EXEC;
          end else begin
            burn_reg <= burn_reg - 2'h1;
          end
        end
        default: state_reg <= ST_EXEC;
      endcase
    end
  end

  // checks
  // each property watches one rule on the flops that carry it;
  // antecedents are gated by the clock enable, so frozen cycles never fire one
  a_skip_no_effect: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && cancel) |=> ($stable(acc_reg) && $stable(b_reg) && !ram_we_reg))
    else $error("cancelled slot changed state");
  a_skip_pc_one: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && cancel) |=> (pc_o == $past(pc_inc)))
    else $error("skip did not step counter by one");
  a_skip_one_cycle: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && cancel && is_multi) |=> !busy_reg)
    else $error("cancelled lookup or return not one cycle");
  a_lookup_len: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && push_go) |=> busy_reg ##1 (busy_reg || !clk_en_i))
    else $error("lookup cycle count wrong");
  a_dp_concat: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && swap_go) |=> (ram_addr_o == $past(dp_cur) &&
      dp_cur == {$past(z_reg), $past(x_reg) ^ $past(op_arg_i), $past(y_reg) + 4'h1}))
    else $error("data pointer or write address wrong");
  a_lookup_push: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && push_go) |=> (sp_reg == $past(sp_reg) + 3'h1))
    else $error("lookup did not raise stack index");
  a_lookup_addr: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && push_go) |=> (rom_addr_o == {$past(op_page_i), $past(d_reg), $past(acc_reg)}))
    else $error("lookup address wrong");
  a_lookup_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && state_reg == ST_LOAD_TBL) |=> (acc_reg == $past(rom_data_i[3:0]) && b_reg == $past(rom_data_i[7:4])))
    else $error("lookup data not loaded");
  a_swap_step: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && swap_go) |=> (ram_we_o && y_reg == $past(y_reg) + 4'h1 && ram_wdata_o == $past(acc_reg)))
    else $error("swap step wrong");
  a_d_to_acc: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_LOAD_ACC_FROM_D) |=> (acc_reg[3] == 1'b0))
    else $error("acc bit 3 not cleared");
  a_e_load: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_LOAD_E_FROM_B_ACC) |=> (e_reg == {$past(b_reg), $past(acc_reg)}))
    else $error("e load wrong");
  a_copy_b_acc: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_COPY_B_TO_ACC) |=> (acc_reg == $past(b_reg)))
    else $error("b to acc copy wrong");
  a_copy_acc_b: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_COPY_ACC_TO_B) |=> (b_reg == $past(acc_reg)))
    else $error("acc to b copy wrong");
  a_copy_y_acc: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_COPY_Y_TO_ACC) |=> (acc_reg == $past(y_reg)))
    else $error("y to acc copy wrong");
  a_copy_acc_y: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_COPY_ACC_TO_Y) |=> (y_reg == $past(acc_reg)))
    else $error("acc to y copy wrong");
  a_e_unload: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_LOAD_B_ACC_FROM_E) |=> ({b_reg, acc_reg} == $past(e_reg)))
    else $error("e unload wrong");
  a_acc_to_d: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_LOAD_D_FROM_ACC) |=> (d_reg == $past(acc_reg[2:0])))
    else $error("d load wrong");
  a_lookup_restore: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && state_reg == ST_LOAD_TBL) |=> (pc_o == $past(sk.rd_data) && sp_reg == $past(sp_reg) - 3'h1))
    else $error("lookup did not restore counter");
  a_stack_save: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && push_go) ##1 clk_en_i |=> (sk.rd_data == $past(pc_inc, 2)))
    else $error("saved counter not in stack entry");
  a_skip_arm: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && do_op && op_code_i == OP_SKIP_IF) |=> (skip_reg == $past(skip_cond_i)))
    else $error("skip not armed from condition");
  a_cancel_len: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    (clk_en_i && cancel) |=> (state_reg == ST_EXEC && !busy_reg))
    else $error("cancelled slot took extra cycles");
endmodule
`default_nettype wire

/* File: ctse_mem_model.sv */
// program rom and data ram model for the transfer core
`timescale 1ns/1ps
`default_nettype none
module ctse_mem_model
  import ctse_pkg::*;
(
  // clock
  input wire logic core_clk_i,
  // rom side
  input wire logic [PC_W-1:0] rom_addr_i,
  output logic [ROM_W-1:0] rom_data_o,
  // ram side
  input wire logic [DP_W-1:0] ram_addr_i,
  input wire logic ram_we_i,
  input wire logic [3:0] ram_wdata_i,
  output logic [3:0] ram_rdata_o
);
  logic [3:0] mem [0:1023]; // ram cells
  // rom word is a fixed scramble of its address
  assign rom_data_o = rom_addr_i[9:0] ^ 10'h2C6;
  // ram reads straight at the pointer
  assign ram_rdata_o = mem[ram_addr_i];
  // preset cells with a known pattern
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = i[3:0] ^ 4'hD;
  end
  // write on the strobe
  always @(posedge core_clk_i) begin
    if (ram_we_i) mem[ram_addr_i] <= ram_wdata_i;
  end
endmodule
`default_nettype wire

/* File: ctse_pkg.sv */
// shared constants and types for the transfer and skip execution block
package ctse_pkg;
  // operation codes presented by the decoder stage
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_COPY_B_TO_ACC = 4'h1;
  localparam logic [3:0] OP_COPY_ACC_TO_B = 4'h2;
  localparam logic [3:0] OP_COPY_Y_TO_ACC = 4'h3;
  localparam logic [3:0] OP_COPY_ACC_TO_Y = 4'h4;
  localparam logic [3:0] OP_LOAD_E_FROM_B_ACC = 4'h5;
  localparam logic [3:0] OP_LOAD_B_ACC_FROM_E = 4'h6;
  localparam logic [3:0] OP_LOAD_D_FROM_ACC = 4'h7;
  localparam logic [3:0] OP_LOAD_ACC_FROM_D = 4'h8;
  localparam logic [3:0] OP_SWAP_MEM_STEP_UP = 4'h9;
  localparam logic [3:0] OP_TABLE_LOOKUP_CALL = 4'hA;
  localparam logic [3:0] OP_RETURN_OP = 4'hB;
  localparam logic [3:0] OP_SKIP_IF = 4'hC;
  // widths
  localparam int PC_W = 14;
  localparam int PAGE_W = 7;
  localparam int DP_W = 10;
  localparam int ROM_W = 10;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  // cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_LOOKUP = 2'h3;
  localparam logic [1:0] CYC_RETURN = 2'h2;
  // reset values
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [PC_W-1:0] PC_RST = 14'h0000;
  localparam logic [SP_W-1:0] SP_RST = 3'h7;
  // execute states
  typedef enum logic [1:0] {ST_EXEC, ST_FETCH_TBL, ST_LOAD_TBL, ST_BURN} ctse_state_t;
endpackage

/* File: ctse_stack.sv */
// eight-entry return stack with registered read
`timescale 1ns/1ps
`default_nettype none
module ctse_stack
  import ctse_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // clock and control
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // port to the core
  ctse_stack_if.mem sk
);
  // storage entries
  logic [PC_W-1:0] mem_reg [DEPTH];
  // registered read out
  logic [PC_W-1:0] rd_reg;
  assign sk.rd_data = rd_reg;
  // write port, no reset on storage
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i && sk.wr_en) begin
      mem_reg[sk.wr_idx] <= sk.wr_data;
    end
  end
  // read port with write bypass
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_reg <= PC_RST;
    end else if (clk_en_i) begin
      rd_reg <= (sk.wr_en && sk.wr_idx == sk.rd_idx) ? sk.wr_data : mem_reg[sk.rd_idx];
    end
  end
endmodule
`default_nettype wire

/* File: ctse_stack_if.sv */
// carrier between the core and its return stack
`timescale 1ns/1ps
`default_nettype none
interface ctse_stack_if;
  logic wr_en; // write strobe
  logic [2:0] wr_idx; // entry written
  logic [13:0] wr_data; // saved counter
  logic [2:0] rd_idx; // entry read
  logic [13:0] rd_data; // registered read data
  modport core (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport mem (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the transfer and skip core
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ctse_pkg::*;
;
  // stimulus
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic op_valid_i = 1'b0;
  logic [3:0] op_code_i = OP_NOP;
  logic [3:0] op_arg_i = 4'h0;
  logic [6:0] op_page_i = 7'h00;
  logic skip_cond_i = 1'b0;
  // design outputs and memory answers
  logic [PC_W-1:0] rom_addr_o, pc_o;
  logic [ROM_W-1:0] rom_data_i;
  logic [DP_W-1:0] ram_addr_o;
  logic ram_we_o, busy_o, skip_pend_o;
  logic [3:0] ram_wdata_o, ram_rdata_i, acc_o, b_o, x_o, y_o;
  logic [7:0] e_o;
  logic [2:0] d_o;
  logic [1:0] z_o;
  logic [SP_W-1:0] sp_o;
  // expected state
  logic [3:0] ea = 4'h0, eb = 4'h0, ex = 4'h0, ey = 4'h0;
  logic [7:0] ee = 8'h00;
  logic [2:0] ed = 3'h0;
  logic [PC_W-1:0] epc = 14'h0000;
  logic [3:0] sh [0:1023]; // shadow of ram
  int mismatches = 0;
  int cmp_count = 0;
  // 40 mhz clock
  always #12.5 core_clk_i = ~core_clk_i;
  ctse_core u_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
    .op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_arg_i(op_arg_i),
    .op_page_i(op_page_i), .skip_cond_i(skip_cond_i),
    .rom_addr_o(rom_addr_o), .rom_data_i(rom_data_i), .ram_addr_o(ram_addr_o),
    .ram_we_o(ram_we_o), .ram_wdata_o(ram_wdata_o), .ram_rdata_i(ram_rdata_i),
    .acc_o(acc_o), .b_o(b_o), .e_o(e_o), .d_o(d_o), .x_o(x_o), .y_o(y_o), .z_o(z_o),
    .pc_o(pc_o), .sp_o(sp_o), .busy_o(busy_o), .skip_pend_o(skip_pend_o)
  );
  ctse_mem_model u_mem (
    .core_clk_i(core_clk_i), .rom_addr_i(rom_addr_o), .rom_data_o(rom_data_i),
    .ram_addr_i(ram_addr_o), .ram_we_i(ram_we_o), .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i)
  );
  // compare and count
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop;
    if (mismatches == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // present one op, taken at the next edge
  task automatic issue(input logic [3:0] code, input logic [3:0] arg, input logic [6:0] pg, input logic c);
    op_valid_i = 1'b1;
    op_code_i = code;
    op_arg_i = arg;
    op_page_i = pg;
    skip_cond_i = c;
    @(posedge core_clk_i);
    #1;
    epc = epc + 14'h0001;
  endtask
  // register view except z and skip flag against the model
  task automatic regs;
    chk("acc", acc_o, ea);
    chk("b", b_o, eb);
    chk("e", e_o, ee);
    chk("d", d_o, ed);
    chk("x", x_o, ex);
    chk("y", y_o, ey);
    chk("pc", pc_o, epc);
    chk("sp", sp_o, 3'h7);
    chk("busy", busy_o, 1'b0);
  endtask
  // plain op, possibly cancelled
  task automatic t_op(input logic [3:0] code, input logic c);
    issue(code, 4'h0, 7'h00, 1'b0);
    if (!c) begin
      case (code)
        OP_COPY_B_TO_ACC: ea = eb;
        OP_COPY_ACC_TO_B: eb = ea;
        OP_COPY_Y_TO_ACC: ea = ey;
        OP_COPY_ACC_TO_Y: ey = ea;
        OP_LOAD_E_FROM_B_ACC: ee = {eb, ea};
        OP_LOAD_B_ACC_FROM_E: {eb, ea} = ee;
        OP_LOAD_D_FROM_ACC: ed = ea[2:0];
        OP_LOAD_ACC_FROM_D: ea = {1'b0, ed};
        default: ;
      endcase
    end
    regs();
  endtask
  // exchange with ram, possibly cancelled
  task automatic t_swap(input logic [3:0] j, input logic c);
    logic [9:0] a;
    logic [3:0] old;
    a = {2'b00, ex, ey};
    old = ea;
    issue(OP_SWAP_MEM_STEP_UP, j, 7'h00, 1'b0);
    if (!c) begin
      ea = sh[a];
      sh[a] = old;
      ex = ex ^ j;
      ey = ey + 4'h1;
      chk("ram wdata", ram_wdata_o, old);
    end
    chk("ram we", ram_we_o, !c);
    // write-back address is the pointer the exchange read from
    chk("ram addr", ram_addr_o, a);
    regs();
  endtask
  // table lookup through the stack
  task automatic t_lookup(input logic [6:0] pg);
    logic [13:0] a;
    logic [9:0] w;
    int n;
    a = {pg, ed, ea};
    w = a[9:0] ^ 10'h2C6;
    issue(OP_TABLE_LOOKUP_CALL, 4'h0, pg, 1'b0);
    op_valid_i = 1'b0;
    chk("sp push", sp_o, 3'h0);
    chk("rom addr", rom_addr_o, a);
    chk("pc load", pc_o, a);
    chk("busy", busy_o, 1'b1);
    n = 0;
    while (busy_o !== 1'b0 && n < 10) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk("lookup wait", n, 2);
    eb = w[7:4];
    ea = w[3:0];
    regs();
  endtask
  // enable low: a held op is not taken and nothing moves
  task automatic t_freeze;
    clk_en_i = 1'b0;
    op_valid_i = 1'b1;
    op_code_i = OP_COPY_ACC_TO_Y;
    repeat (3) @(posedge core_clk_i);
    #1;
    regs();
    clk_en_i = 1'b1;
  endtask
  // skip then the next op
  task automatic t_skip(input logic c, input logic [3:0] code);
    issue(OP_SKIP_IF, 4'h0, 7'h00, c);
    chk("skip pend", skip_pend_o, c);
    if (code == OP_SWAP_MEM_STEP_UP) t_swap(4'h6, c);
    else t_op(code, c);
    chk("skip clear", skip_pend_o, 1'b0);
  endtask
  // watchdog
  initial begin
    #50000;
    mismatches++;
    report_and_stop();
  end
  // main sequence
  initial begin
    for (int i = 0; i < 1024; i++) sh[i] = i[3:0] ^ 4'hD;
    repeat (4) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    regs();
    t_swap(4'hA, 1'b0);
    t_op(OP_LOAD_D_FROM_ACC, 1'b0);
    t_freeze();
    t_op(OP_COPY_ACC_TO_B, 1'b0);
    t_swap(4'h3, 1'b0);
    t_op(OP_LOAD_E_FROM_B_ACC, 1'b0);
    t_op(OP_COPY_ACC_TO_Y, 1'b0);
    t_op(OP_COPY_B_TO_ACC, 1'b0);
    t_op(OP_COPY_Y_TO_ACC, 1'b0);
    t_op(OP_LOAD_ACC_FROM_D, 1'b0);
    t_op(OP_COPY_ACC_TO_B, 1'b0);
    t_op(OP_LOAD_B_ACC_FROM_E, 1'b0);
    t_lookup(7'h15);
    t_skip(1'b1, OP_SWAP_MEM_STEP_UP);
    t_skip(1'b1, OP_TABLE_LOOKUP_CALL);
    t_skip(1'b1, OP_RETURN_OP);
    t_skip(1'b1, OP_COPY_Y_TO_ACC);
    t_skip(1'b0, OP_SWAP_MEM_STEP_UP);
    report_and_stop();
  end
endmodule
`default_nettype wire
